//--- hw/dgdi_interlock.sv
`timescale 1ns/1ps
module dgdi_interlock
    import dgdi_pkg::*;
#(
    parameter logic [DGDI_HOLD_W-1:0] HOLD_LONG_CYC = DGDI_HOLD_W'(DGDI_HOLD_LONG_CYC),
    parameter logic [DGDI_HOLD_W-1:0] HOLD_SHORT_CYC = DGDI_HOLD_W'(DGDI_HOLD_SHORT_CYC)
) (
    input wire logic core_clk, // 10 MHz clock
    input wire logic reset, // async, active high
    input wire logic topology_select, // 1 = direct, 0 = half-bridge
    input wire logic pwm_or_ch1_command, // ch1 command or pwm
    input wire logic ch2_or_enable_command, // ch2 command or enable
    input wire logic hold_time_setting_pin, // 1 = open (long), 0 = grounded (short)
    input wire logic [DGDI_GAP_W-1:0] dead_gap, // dead gap in clock cycles
    input wire logic primary_uv, // primary undervoltage_lockout level
    input wire logic [DGDI_NCH-1:0] secondary_uv, // per-channel secondary undervoltage
    output logic gate_ch1, // gate one on
    output logic gate_ch2, // gate two on
    output dgdi_od_type fault_flag_ch1, // open-drain fault, channel one
    output dgdi_od_type fault_flag_ch2 // open-drain fault, channel two
);
    // hold length picked from the setting pin
    logic [DGDI_HOLD_W-1:0] hold_len;
    assign hold_len = hold_time_setting_pin ? HOLD_LONG_CYC : HOLD_SHORT_CYC;

    // primary lockout: count starts once the fault clears
    logic [DGDI_HOLD_W-1:0] prim_cnt_q, prim_cnt_d;
    logic prim_lock_q, prim_lock_d;
    logic boot_q; // high until the first edge after reset
    // reset starts in lockout with a full count pending
    always_comb begin
        prim_lock_d = prim_lock_q;
        prim_cnt_d = prim_cnt_q;
        if (primary_uv || boot_q) begin
            prim_lock_d = 1'b1;
            prim_cnt_d = hold_len; // held until clear; boot loads the pin's length
        end else if (prim_lock_q) begin
            if (prim_cnt_q <= DGDI_HOLD_W'(1)) begin
                prim_lock_d = 1'b0;
                prim_cnt_d = '0;
            end else begin
                prim_cnt_d = prim_cnt_q - DGDI_HOLD_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prim_lock_q <= 1'b1;
            prim_cnt_q <= '0; // loaded from the hold pin on the first edge
        end else begin
            prim_lock_q <= prim_lock_d;
            prim_cnt_q <= prim_cnt_d;
        end
    end

    // first edge after reset loads the real hold length so the pin is honoured
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // secondary lockout per channel: count runs from detection
    logic [DGDI_NCH-1:0] sec_lock_q, sec_lock_d, sec_uv_prev_q;
    logic [DGDI_HOLD_W-1:0] sec_cnt_q [DGDI_NCH];
    logic [DGDI_HOLD_W-1:0] sec_cnt_d [DGDI_NCH];
    genvar g;
    generate
        for (g = 0; g < DGDI_NCH; g++) begin : g_sec
            // a fresh detection restarts the count; an already-low supply keeps the gate off
            always_comb begin
                sec_lock_d[g] = sec_lock_q[g];
                sec_cnt_d[g] = sec_cnt_q[g];
                if (secondary_uv[g] && !sec_uv_prev_q[g]) begin
                    sec_lock_d[g] = 1'b1;
                    sec_cnt_d[g] = hold_len;
                end else if (sec_lock_q[g]) begin
                    if (sec_cnt_q[g] <= DGDI_HOLD_W'(1)) begin
                        sec_lock_d[g] = secondary_uv[g]; // stays while still low
                        sec_cnt_d[g] = '0;
                    end else begin
                        sec_cnt_d[g] = sec_cnt_q[g] - DGDI_HOLD_W'(1);
                    end
                end
            end

            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    sec_lock_q[g] <= 1'b0;
                    sec_cnt_q[g] <= '0;
                    sec_uv_prev_q[g] <= 1'b0;
                end else begin
                    sec_lock_q[g] <= sec_lock_d[g];
                    sec_cnt_q[g] <= sec_cnt_d[g];
                    sec_uv_prev_q[g] <= secondary_uv[g];
                end
            end
        end
    endgenerate

    // half-bridge sequencer with dead gap counter
    dgdi_hb_type hb_q, hb_d;
    logic [DGDI_GAP_W-1:0] gap_cnt_q, gap_cnt_d;
    logic hb_ch1, hb_ch2;
    logic ch2_on_q, ch2_on_d;
    always_comb begin
        hb_d = hb_q;
        gap_cnt_d = gap_cnt_q;
        if (!ch2_or_enable_command) begin
            hb_d = DGDI_HB_OFF;
            gap_cnt_d = '0;
        end else begin
            case (hb_q)
                DGDI_HB_OFF: begin
                    // enable just rose: apply the gap before whichever gate pwm selects
                    // while ch2 is already on, stay here instead of re-arming a gap
                    if (pwm_or_ch1_command) begin
                        hb_d = DGDI_HB_GAP_TO_CH1;
                        gap_cnt_d = dead_gap;
                    end else if (!ch2_on_q) begin
                        hb_d = DGDI_HB_GAP_TO_CH2;
                        gap_cnt_d = dead_gap;
                    end
                end
                DGDI_HB_GAP_TO_CH1: begin
                    if (!pwm_or_ch1_command) begin
                        hb_d = DGDI_HB_GAP_TO_CH2; // restart gap on reversal
                        gap_cnt_d = dead_gap;
                    end else if (gap_cnt_q <= DGDI_GAP_W'(1)) begin
                        hb_d = DGDI_HB_CH1_ON;
                    end else begin
                        gap_cnt_d = gap_cnt_q - DGDI_GAP_W'(1);
                    end
                end
                DGDI_HB_CH1_ON: begin
                    if (!pwm_or_ch1_command) begin
                        hb_d = DGDI_HB_GAP_TO_CH2; // ch1 off at once
                        gap_cnt_d = dead_gap;
                    end
                end
                DGDI_HB_GAP_TO_CH2: begin
                    if (pwm_or_ch1_command) begin
                        hb_d = DGDI_HB_GAP_TO_CH1; // ch2 off at once
                        gap_cnt_d = dead_gap;
                    end else if (gap_cnt_q <= DGDI_GAP_W'(1)) begin
                        hb_d = DGDI_HB_OFF; // marks ch2 on via gap done below
                        gap_cnt_d = '0;
                    end else begin
                        gap_cnt_d = gap_cnt_q - DGDI_GAP_W'(1);
                    end
                end
                default: begin
                    hb_d = DGDI_HB_OFF;
                    gap_cnt_d = '0;
                end
            endcase
        end
    end

    // ch2 on state: OFF with enable high and gap already spent
    always_comb begin
        ch2_on_d = ch2_on_q;
        if (!ch2_or_enable_command || pwm_or_ch1_command) begin
            ch2_on_d = 1'b0;
        end else if (hb_q == DGDI_HB_GAP_TO_CH2 && gap_cnt_q <= DGDI_GAP_W'(1)) begin
            ch2_on_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hb_q <= DGDI_HB_OFF;
            gap_cnt_q <= '0;
            ch2_on_q <= 1'b0;
        end else begin
            hb_q <= hb_d;
            gap_cnt_q <= gap_cnt_d;
            ch2_on_q <= ch2_on_d;
        end
    end

    // ch2 on keeps OFF from re-arming the gap to ch2 while pwm stays low
    assign hb_ch1 = (hb_q == DGDI_HB_CH1_ON) && pwm_or_ch1_command && ch2_or_enable_command;
    assign hb_ch2 = ch2_on_q && !pwm_or_ch1_command && ch2_or_enable_command;

    // output stage: topology mux and lockout gating, all registered
    logic gate_ch1_d, gate_ch2_d;
    logic [DGDI_NCH-1:0] fault_d;
    logic [DGDI_NCH-1:0] fault_q;
    always_comb begin
        if (topology_select) begin
            gate_ch1_d = pwm_or_ch1_command;
            gate_ch2_d = ch2_or_enable_command;
        end else begin
            gate_ch1_d = hb_ch1;
            gate_ch2_d = hb_ch2;
        end
        // lockouts override commands; next-state used so faults act the same edge
        if (prim_lock_d || sec_lock_d[DGDI_CH1] || boot_q) begin
            gate_ch1_d = 1'b0;
        end
        if (prim_lock_d || sec_lock_d[DGDI_CH2] || boot_q) begin
            gate_ch2_d = 1'b0;
        end
        fault_d[DGDI_CH1] = prim_lock_d || sec_lock_d[DGDI_CH1];
        fault_d[DGDI_CH2] = prim_lock_d || sec_lock_d[DGDI_CH2];
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            gate_ch1 <= 1'b0;
            gate_ch2 <= 1'b0;
            fault_q <= '1;
        end else begin
            gate_ch1 <= gate_ch1_d;
            gate_ch2 <= gate_ch2_d;
            fault_q <= fault_d;
        end
    end

    // open drain: drive low only during a fault
    assign fault_flag_ch1 = '{o: 1'b0, oe: fault_q[DGDI_CH1]};
    assign fault_flag_ch2 = '{o: 1'b0, oe: fault_q[DGDI_CH2]};

    // shoot-through guard in half-bridge
    property p_no_overlap;
        @(posedge core_clk) disable iff (reset) !$past(topology_select) |-> !(gate_ch1 && gate_ch2);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on in half-bridge");

    // gates lag the topology pin by one edge, so the mode is taken from the edge before
    property p_gap_before_ch1;
        @(posedge core_clk) disable iff (reset) (!$past(topology_select) && $rose(gate_ch1)) |-> !$past(gate_ch2);
    endproperty
    a_gap_before_ch1: assert property (p_gap_before_ch1) else $error("gate one on without a gap");

    property p_direct;
        @(posedge core_clk) disable iff (reset)
            (topology_select && !prim_lock_d && !sec_lock_d[0] && !boot_q) |=> gate_ch1 == $past(pwm_or_ch1_command);
    endproperty
    a_direct: assert property (p_direct) else $error("direct gate one wrong");

    property p_enable_off;
        @(posedge core_clk) disable iff (reset) (!topology_select && !ch2_or_enable_command) |=> !gate_ch1 && !gate_ch2;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("gates on while disabled");

    property p_prim_off;
        @(posedge core_clk) disable iff (reset) primary_uv |=> !gate_ch1 && !gate_ch2 && fault_flag_ch1.oe && fault_flag_ch2.oe;
    endproperty
    a_prim_off: assert property (p_prim_off) else $error("primary lockout not applied");

    property p_prim_hold;
        @(posedge core_clk) disable iff (reset) $fell(primary_uv) |=> fault_flag_ch1.oe [*3];
    endproperty
    a_prim_hold: assert property (p_prim_hold) else $error("fault released too early");

    property p_sec_fault;
        @(posedge core_clk) disable iff (reset) $rose(secondary_uv[1]) |=> fault_flag_ch2.oe && !gate_ch2;
    endproperty
    a_sec_fault: assert property (p_sec_fault) else $error("secondary fault not shown");

    property p_sec_count;
        @(posedge core_clk) disable iff (reset) $rose(secondary_uv[0]) |=> sec_cnt_q[0] == hold_len;
    endproperty
    a_sec_count: assert property (p_sec_count) else $error("hold count not restarted");

    property p_od;
        @(posedge core_clk) disable iff (reset) fault_flag_ch1.o == 1'b0 && fault_flag_ch2.o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("fault pin driven high");
endmodule // dgdi_interlock

//--- pkg/dgdi_pkg.sv
package dgdi_pkg;
    // clock rate and documented times
    localparam int unsigned DGDI_CLK_HZ = 10_000_000;
    localparam int unsigned DGDI_HOLD_LONG_US = 95_000; // 95 ms, hold pin open
    localparam int unsigned DGDI_HOLD_SHORT_US = 10; // 10 us, hold pin grounded
    localparam int unsigned DGDI_HOLD_LONG_CYC = DGDI_HOLD_LONG_US * (DGDI_CLK_HZ / 1_000_000);
    localparam int unsigned DGDI_HOLD_SHORT_CYC = DGDI_HOLD_SHORT_US * (DGDI_CLK_HZ / 1_000_000);
    // counter widths
    localparam int unsigned DGDI_HOLD_W = 24;
    localparam int unsigned DGDI_GAP_W = 16;
    localparam int unsigned DGDI_DEAD_GAP_DEFAULT = 10;
    // channel indices
    localparam int unsigned DGDI_CH1 = 0;
    localparam int unsigned DGDI_CH2 = 1;
    localparam int unsigned DGDI_NCH = 2;

    // per-channel open-drain fault pin: value driven and its enable
    typedef struct packed {
        logic o;
        logic oe;
    } dgdi_od_type;

    // half-bridge dead gap sequencer states
    typedef enum logic [1:0] {
        DGDI_HB_OFF,
        DGDI_HB_GAP_TO_CH1,
        DGDI_HB_CH1_ON,
        DGDI_HB_GAP_TO_CH2
    } dgdi_hb_type;
endpackage

//--- verif/dgdi_host_model.sv
`timescale 1ns/1ps
// host side: drives both command inputs and reads the open-drain fault pins
module dgdi_host_model
    import dgdi_pkg::*;
(
    input wire logic core_clk, // bench clock
    input wire logic [1:0] want, // requested command levels
    input wire dgdi_od_type flag_ch1, // fault pin, channel one
    input wire dgdi_od_type flag_ch2, // fault pin, channel two
    output logic cmd1, // first command input
    output logic cmd2, // second command input
    output logic [1:0] fault_n // pin levels, bit0 channel one
);
    logic fell, next1, next2;

    // board pull-ups: a released pin reads high
    assign fault_n = {flag_ch2.oe ? flag_ch2.o : 1'b1, flag_ch1.oe ? flag_ch1.o : 1'b1};

    // falls go out at once, rises wait one cycle after any fall,
    // so complementary direct commands never overlap
    initial begin
        cmd1 = 1'b0;
        cmd2 = 1'b0;
        forever begin
            @(posedge core_clk);
            // want is read on the edge, before the bench moves it, to avoid a race
            fell = (cmd1 & ~want[0]) | (cmd2 & ~want[1]);
            next1 = fell ? (cmd1 & want[0]) : want[0];
            next2 = fell ? (cmd2 & want[1]) : want[1];
            #1;
            cmd1 = next1;
            cmd2 = next2;
        end
    end
endmodule // dgdi_host_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench
    import dgdi_pkg::*;
;
    logic core_clk, reset, topology_select, hold_time_setting_pin, primary_uv;
    logic cmd1, cmd2, gate_ch1, gate_ch2;
    logic [1:0] secondary_uv, want, fault_n;
    logic [DGDI_GAP_W-1:0] dead_gap;
    dgdi_od_type ff1, ff2;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int g;

    // short hold lengths keep the run brief: 50 long, 10 short
    dgdi_interlock #(.HOLD_LONG_CYC(24'h00_0032), .HOLD_SHORT_CYC(24'h00_000a)) u_dgdi_interlock (
        .core_clk(core_clk), .reset(reset), .topology_select(topology_select),
        .pwm_or_ch1_command(cmd1), .ch2_or_enable_command(cmd2),
        .hold_time_setting_pin(hold_time_setting_pin), .dead_gap(dead_gap),
        .primary_uv(primary_uv), .secondary_uv(secondary_uv), .gate_ch1(gate_ch1),
        .gate_ch2(gate_ch2), .fault_flag_ch1(ff1), .fault_flag_ch2(ff2));

    dgdi_host_model u_dgdi_host_model (
        .core_clk(core_clk), .want(want), .flag_ch1(ff1), .flag_ch2(ff2),
        .cmd1(cmd1), .cmd2(cmd2), .fault_n(fault_n));

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // fault pin must only ever sink: o is low whenever oe drives
    task automatic chk_out(input logic [1:0] gates, input logic [1:0] faults);
        check({2'b00, ff2.o & ff2.oe, ff1.o & ff1.oe, gate_ch2, gate_ch1, fault_n}, {4'h0, gates, faults});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // cycle ceiling cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        reset = 1'b1;
        topology_select = 1'b1;
        hold_time_setting_pin = 1'b1;
        primary_uv = 1'b0;
        secondary_uv = 2'b00;
        want = 2'b00;
        dead_gap = 16'h0002;
        void'($urandom(32'h8338_1057));
        cyc(2);
        chk_out(2'b00, 2'b00);
        cyc(3);
        reset = 1'b0;
        want = 2'b11;
        cyc(45);
        chk_out(2'b00, 2'b00);
        cyc(12);
        chk_out(2'b11, 2'b11);
        // random independent direct commands
        for (int i = 0; i < 8; i++) begin
            want = 2'($urandom);
            cyc(4);
            chk_out(want, 2'b11);
        end
        // half-bridge: want[1] enable, want[0] pwm, random gap
        hold_time_setting_pin = 1'b0;
        topology_select = 1'b0;
        for (int i = 0; i < 3; i++) begin
            g = 2 + ($urandom % 5);
            dead_gap = 16'(g);
            want = 2'b10;
            cyc(g + 8);
            chk_out(2'b10, 2'b11);
            want = 2'b11;
            cyc(3);
            chk_out(2'b00, 2'b11);
            cyc(g + 3);
            chk_out(2'b01, 2'b11);
            want = 2'b10;
            cyc(3);
            chk_out(2'b00, 2'b11);
            cyc(g + 3);
            chk_out(2'b10, 2'b11);
            want = 2'b01;
            cyc(4);
            chk_out(2'b00, 2'b11);
        end
        // primary undervoltage, hold counted from clearing
        topology_select = 1'b1;
        want = 2'b11;
        cyc(4);
        primary_uv = 1'b1;
        cyc(2);
        chk_out(2'b00, 2'b00);
        cyc(3);
        primary_uv = 1'b0;
        cyc(8);
        chk_out(2'b00, 2'b00);
        cyc(6);
        chk_out(2'b11, 2'b11);
        // secondary undervoltage, hold counted from detection
        secondary_uv = 2'b10;
        cyc(2);
        chk_out(2'b01, 2'b01);
        cyc(4);
        secondary_uv = 2'b00;
        cyc(8);
        chk_out(2'b11, 2'b11);
        // a second fault inside the hold restarts it
        secondary_uv = 2'b01;
        cyc(3);
        secondary_uv = 2'b00;
        cyc(3);
        secondary_uv = 2'b01;
        cyc(2);
        secondary_uv = 2'b00;
        cyc(5);
        chk_out(2'b10, 2'b10);
        cyc(7);
        chk_out(2'b11, 2'b11);
        // reset in mid-run with the short hold: lockout reloads from the pin
        reset = 1'b1;
        cyc(2);
        chk_out(2'b00, 2'b00);
        reset = 1'b0;
        cyc(9);
        chk_out(2'b00, 2'b00);
        cyc(4);
        chk_out(2'b11, 2'b11);
        wrap_up();
    end
endmodule // testbench
